// >>> hvf_pkg.sv
/*
 * hvf_pkg: constants, states and carrier types shared by the two-dimensional
 * image filter core and its coefficient loaders.
 * Assumes a single rising-edge clock and a synchronous active-high reset.
 */
package hvf_pkg;

	// ****************************************************************
	// widths and sizes
	// ****************************************************************
	localparam int PIX_W = 12;
	localparam int ROWS = 256;
	localparam int ROW_W = 8;
	localparam int NCOEF = 8;
	localparam int HTAPS = 16;
	localparam int VTAPS = 8;
	localparam int LB_COUNT = 7;
	localparam int LB_DEPTH = 3076;
	localparam int PTR_W = 12;
	localparam int HSR_DEPTH = 256;
	localparam int ACC_W = 32;
	localparam int RSL_COUNT = 16;
	localparam int FIFO_DEPTH = 16;
	localparam logic [PTR_W-1:0] LINE_MIN = 12'h0004;
	localparam logic [PTR_W-1:0] LINE_MAX = 12'h0c04;
	localparam logic [4:0] SEL_MAX = 5'h14;

	// ****************************************************************
	// load word layout and configuration map
	// ****************************************************************
	localparam int HDR_CFG_BIT = 11;
	localparam int COEF_LAST = 7;
	localparam logic [4:0] CFG_MODE_IDX = 5'h10;
	localparam logic [4:0] CFG_LB_MODE_IDX = 5'h11;
	localparam logic [4:0] CFG_LINE_LEN_IDX = 5'h12;
	localparam logic [4:0] CFG_INTLV_IDX = 5'h13;
	localparam int MODE_ORTHO_BIT = 0;
	localparam int MODE_ORDER_BIT = 1;
	localparam int MODE_SYM_BIT = 2;
	localparam int RSL_SEL_MSB = 4;
	localparam int RSL_ROUND_BIT = 5;
	localparam int RSL_LIMIT_BIT = 6;
	localparam int INTLV_MSB = 3;
	localparam int DECIM_LSB = 4;
	localparam int DECIM_MSB = 7;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [PIX_W-1:0] MODE_RST = 12'h0000;
	localparam logic [PIX_W-1:0] LB_MODE_RST = 12'h0000;
	localparam logic [PIX_W-1:0] LINE_LEN_RST = 12'h0c00;
	localparam logic [PIX_W-1:0] INTLV_RST = 12'h0000;
	localparam logic [PIX_W-1:0] RSL_RST = 12'h0000;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef logic signed [PIX_W-1:0] hvf_pix_t;
	typedef enum logic [2:0] {
		LD_WAIT = 3'b001,
		LD_DATA = 3'b010,
		LD_DONE = 3'b100
	} hvf_ld_state_t;
	typedef struct packed {
		logic en;
		logic is_cfg;
		logic [ROW_W-1:0] row;
		logic [4:0] idx;
		logic [PIX_W-1:0] data;
	} hvf_ld_wr_t;

endpackage : hvf_pkg

// >>> hvf_filter.sv
/*
 * hvf_filter: horizontal/vertical image filter core, its coefficient load
 * sequencer and the output FIFO.
 * Assumes all inputs are synchronous to clk_i and the sink drains pixel_out_o
 * with out_ready_i; the tri-state pad is resolved outside from pixel_out_oe_o.
 */
// Notes on behaviour
// - all state changes only on the rising master clock edge
// - input register takes one 12-bit pixel each enabled edge
// - pixels, coefficients and outputs are 12-bit two's complement
// - pixel output comes from a register
// - horizontal load word taken only while its strobe is low
// - horizontal strobe high means nothing is taken
// - loading starts only after a high-to-low strobe transition
// - horizontal row address latched while its enable is low
// - vertical load word taken only while its strobe is low
// - vertical row address latched while its enable is low
// - 256 horizontal and 256 vertical coefficient sets stored
// - writes touch only the addressed set of the loading filter
// - horizontal filter: 16 taps symmetric, 8 taps asymmetric
// - vertical 8-tap filter uses only on-chip line buffers
// - seven 12-bit line buffers, each delay or bypass mode
// - line length programmable from 4 to 3076 pixels
// - interleaved lines handled directly by the line buffers
// - horizontal taps spaced by up to sixteen interleaved sets
// - horizontal decimation up to 16:1
// - select code n takes accumulator bits n+11..n, rounded and limited
// - filters run cascaded or concurrently on the same input
// - address register holds while its enable is high
// - output driven while output enable low, released while high
// - cascade order bit: 0 horizontal first, 1 vertical first
// - four-bit selects latched each edge pick one of sixteen format registers

// ****************************************************************
// small synchronous FIFO
// ****************************************************************
module hvf_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	// honest full and empty from the occupancy count
	assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_ptr_reg];

	// storage, no reset needed
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	// pointers and count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : hvf_fifo

// ****************************************************************
// coefficient load sequencer: header word, then data words
// ****************************************************************
module hvf_coef_loader (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic strobe_n_i,
	input wire logic [hvf_pkg::PIX_W-1:0] word_i,
	output hvf_pkg::hvf_ld_wr_t wr_o
);
	import hvf_pkg::*;
	hvf_ld_state_t state_reg;
	logic strobe_prev_reg;
	logic is_cfg_reg;
	logic [ROW_W-1:0] row_reg;
	logic [4:0] idx_reg;
	logic [2:0] cnt_reg;

	// previous strobe level
	// starts low so a strobe already low at reset cannot open a load
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_prev_reg <= 1'b0;
		end else begin
			strobe_prev_reg <= strobe_n_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= LD_WAIT;
			is_cfg_reg <= 1'b0;
			row_reg <= '0;
			idx_reg <= '0;
			cnt_reg <= '0;
		end else begin
			case (state_reg)
				LD_WAIT: begin
					if (!strobe_n_i && strobe_prev_reg) begin
						is_cfg_reg <= word_i[HDR_CFG_BIT];
						row_reg <= word_i[ROW_W-1:0];
						idx_reg <= word_i[4:0];
						cnt_reg <= '0;
						state_reg <= LD_DATA;
					end
				end
				LD_DATA: begin
					if (strobe_n_i) begin
						state_reg <= LD_WAIT;
					end else begin
						cnt_reg <= cnt_reg + 3'h1;
						if (is_cfg_reg || (cnt_reg == 3'(COEF_LAST))) begin
							state_reg <= LD_DONE;
						end
					end
				end
				LD_DONE: begin
					if (strobe_n_i) begin
						state_reg <= LD_WAIT;
					end
				end
				default: begin
					state_reg <= LD_WAIT;
				end
			endcase
		end
	end

	// write request, one per data word taken
	always_comb begin
		wr_o.en = (state_reg == LD_DATA) && !strobe_n_i;
		wr_o.is_cfg = is_cfg_reg;
		wr_o.row = row_reg;
		wr_o.idx = is_cfg_reg ? idx_reg : {2'b00, cnt_reg};
		wr_o.data = word_i;
	end
endmodule : hvf_coef_loader

// ****************************************************************
// filter core
// ****************************************************************
module hvf_filter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire hvf_pkg::hvf_pix_t pixel_in_i,
	input wire logic pixel_valid_i,
	output logic pixel_ready_o,
	input wire logic [hvf_pkg::PIX_W-1:0] horiz_coef_in_i,
	input wire logic horiz_load_strobe_n_i,
	input wire logic [hvf_pkg::ROW_W-1:0] horiz_coef_row_addr_i,
	input wire logic horiz_addr_latch_en_n_i,
	input wire logic [hvf_pkg::PIX_W-1:0] vert_coef_in_i,
	input wire logic vert_load_strobe_n_i,
	input wire logic [hvf_pkg::ROW_W-1:0] vert_coef_row_addr_i,
	input wire logic vert_addr_latch_en_n_i,
	input wire logic [3:0] horiz_format_reg_select_i,
	input wire logic [3:0] vert_format_reg_select_i,
	input wire logic out_en_n_i,
	input wire logic out_ready_i,
	output hvf_pkg::hvf_pix_t pixel_out_o,
	output logic pixel_out_oe_o,
	output logic pixel_out_valid_o
);
	import hvf_pkg::*;

	// select, round and limit one accumulator into 12 bits
	function automatic hvf_pix_t fmt(input logic signed [ACC_W-1:0] acc,
			input logic [PIX_W-1:0] round_select_limit);
		logic [4:0] n;
		logic signed [ACC_W-1:0] v;
		n = (round_select_limit[RSL_SEL_MSB:0] > SEL_MAX) ? SEL_MAX : round_select_limit[RSL_SEL_MSB:0];
		v = acc;
		if (round_select_limit[RSL_ROUND_BIT] && (n != 5'h00)) begin
			v = v + (ACC_W'(1) <<< (n - 5'h01));
		end
		v = v >>> n;
		return round_select_limit[RSL_LIMIT_BIT] ? sat(v) : v[PIX_W-1:0];
	endfunction : fmt

	// saturate to the 12-bit signed range
	function automatic hvf_pix_t sat(input logic signed [ACC_W-1:0] v);
		if (v > ACC_W'(2047)) begin
			return 12'sh7ff;
		end else if (v < -ACC_W'(2048)) begin
			return 12'sh800;
		end
		return v[PIX_W-1:0];
	endfunction : sat

	hvf_ld_wr_t h_wr;
	hvf_ld_wr_t v_wr;
	hvf_ld_wr_t cfg_wr;
	logic [ROW_W-1:0] h_row_reg;
	logic [ROW_W-1:0] v_row_reg;
	logic [3:0] h_rsl_sel_reg;
	logic [3:0] v_rsl_sel_reg;
	logic signed [PIX_W-1:0] h_coef_mem [0:ROWS*NCOEF-1];
	logic signed [PIX_W-1:0] v_coef_mem [0:ROWS*NCOEF-1];
	logic [PIX_W-1:0] rsl_reg [0:RSL_COUNT-1];
	logic [PIX_W-1:0] mode_reg;
	logic [PIX_W-1:0] lb_mode_reg;
	logic [PIX_W-1:0] line_len_reg;
	logic [PIX_W-1:0] intlv_reg;
	hvf_pix_t in_reg;
	hvf_pix_t h_fmt_reg;
	hvf_pix_t v_fmt_reg;
	logic in_v_reg;
	logic s2_v_reg;
	logic s3_v_reg;
	hvf_pix_t hsr [0:HSR_DEPTH-1];
	logic [PIX_W-1:0] lb_mem [0:LB_COUNT-1][0:LB_DEPTH-1];
	logic [PTR_W-1:0] lb_ptr_reg;
	logic [PTR_W-1:0] line_len;
	logic [3:0] dec_cnt_reg;
	hvf_pix_t hin;
	hvf_pix_t vin;
	hvf_pix_t htap [0:HTAPS-1];
	hvf_pix_t vtap [0:VTAPS-1];
	logic signed [ACC_W-1:0] h_acc;
	logic signed [ACC_W-1:0] v_acc;
	hvf_pix_t res;
	logic res_v;
	logic adv;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic out_load;
	hvf_pix_t fifo_out_data;
	hvf_pix_t pixel_out_reg;
	logic out_v_reg;
	logic ortho;
	logic [4:0] spacing;

	hvf_coef_loader u_h_loader (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.strobe_n_i(horiz_load_strobe_n_i),
		.word_i(horiz_coef_in_i),
		.wr_o(h_wr)
	);
	hvf_coef_loader u_v_loader (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.strobe_n_i(vert_load_strobe_n_i),
		.word_i(vert_coef_in_i),
		.wr_o(v_wr)
	);

	// ****************************************************************
	// address and format selects
	// ****************************************************************
	// rising-edge only registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			h_row_reg <= '0;
			v_row_reg <= '0;
			h_rsl_sel_reg <= '0;
			v_rsl_sel_reg <= '0;
		end else begin
			if (!horiz_addr_latch_en_n_i) begin
				h_row_reg <= horiz_coef_row_addr_i;
			end
			if (!vert_addr_latch_en_n_i) begin
				v_row_reg <= vert_coef_row_addr_i;
			end
			h_rsl_sel_reg <= horiz_format_reg_select_i;
			v_rsl_sel_reg <= vert_format_reg_select_i;
		end
	end

	// ****************************************************************
	// coefficient banks and configuration
	// ****************************************************************
	// per-filter banks, one word per write
	always_ff @(posedge clk_i) begin
		if (h_wr.en && !h_wr.is_cfg) begin
			h_coef_mem[{h_wr.row, h_wr.idx[2:0]}] <= h_wr.data;
		end
		if (v_wr.en && !v_wr.is_cfg) begin
			v_coef_mem[{v_wr.row, v_wr.idx[2:0]}] <= v_wr.data;
		end
	end

	// either port may reach the shared registers; horizontal wins a tie
	assign cfg_wr = (h_wr.en && h_wr.is_cfg) ? h_wr : v_wr;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= MODE_RST;
			lb_mode_reg <= LB_MODE_RST;
			line_len_reg <= LINE_LEN_RST;
			intlv_reg <= INTLV_RST;
			for (int i = 0; i < RSL_COUNT; i++) begin
				rsl_reg[i] <= RSL_RST;
			end
		end else if (cfg_wr.en && cfg_wr.is_cfg) begin
			if (cfg_wr.idx < 5'(RSL_COUNT)) begin
				rsl_reg[cfg_wr.idx[3:0]] <= cfg_wr.data;
			end
			if (cfg_wr.idx == CFG_MODE_IDX) begin
				mode_reg <= cfg_wr.data;
			end
			if (cfg_wr.idx == CFG_LB_MODE_IDX) begin
				lb_mode_reg <= cfg_wr.data;
			end
			if (cfg_wr.idx == CFG_LINE_LEN_IDX) begin
				line_len_reg <= cfg_wr.data;
			end
			if (cfg_wr.idx == CFG_INTLV_IDX) begin
				intlv_reg <= cfg_wr.data;
			end
		end
	end

	// ****************************************************************
	// data path routing
	// ****************************************************************
	// the whole pipe moves only with a new sample; results drain as samples arrive
	assign adv = pixel_valid_i && fifo_in_ready;
	assign pixel_ready_o = fifo_in_ready;
	assign ortho = mode_reg[MODE_ORTHO_BIT];

	always_comb begin
		if (ortho) begin
			hin = in_reg;
			vin = in_reg;
		end else if (mode_reg[MODE_ORDER_BIT]) begin
			vin = in_reg;
			hin = v_fmt_reg;
		end else begin
			hin = in_reg;
			vin = h_fmt_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_reg <= '0;
			in_v_reg <= 1'b0;
		end else if (adv) begin
			in_reg <= pixel_in_i;
			in_v_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// horizontal filter
	// ****************************************************************
	// tap spacing equals the interleave depth, 1 to 16
	assign spacing = {1'b0, intlv_reg[INTLV_MSB:0]} + 5'h01;

	always_ff @(posedge clk_i) begin
		if (adv) begin
			hsr[0] <= hin;
			for (int i = 1; i < HSR_DEPTH; i++) begin
				hsr[i] <= hsr[i-1];
			end
		end
	end

	// symmetric pre-add or plain 8 taps
	always_comb begin
		h_acc = '0;
		htap[0] = hin;
		for (int k = 1; k < HTAPS; k++) begin
			htap[k] = hsr[8'(k * int'(spacing) - 1)];
		end
		for (int k = 0; k < NCOEF; k++) begin
			if (mode_reg[MODE_SYM_BIT]) begin
				h_acc = h_acc + ACC_W'(h_coef_mem[{h_row_reg, 3'(k)}])
					* (ACC_W'(htap[k]) + ACC_W'(htap[HTAPS-1-k]));
			end else begin
				h_acc = h_acc + ACC_W'(h_coef_mem[{h_row_reg, 3'(k)}]) * ACC_W'(htap[k]);
			end
		end
	end

	// ****************************************************************
	// vertical filter and line buffers
	// ****************************************************************
	// clamp length to the supported span
	assign line_len = (line_len_reg < LINE_MIN) ? LINE_MIN :
		(line_len_reg > LINE_MAX) ? LINE_MAX : line_len_reg;

	// each buffer delays a line or is bypassed
	// tap 0 is the input; later taps come from on-chip buffers or the tap before
	always_comb begin
		v_acc = '0;
		vtap[0] = vin;
		for (int k = 1; k < VTAPS; k++) begin
			vtap[k] = lb_mode_reg[k-1] ? vtap[k-1] : lb_mem[k-1][lb_ptr_reg];
		end
		for (int k = 0; k < VTAPS; k++) begin
			v_acc = v_acc + ACC_W'(v_coef_mem[{v_row_reg, 3'(k)}]) * ACC_W'(vtap[k]);
		end
	end

	// interleaved lines just form a longer circular line
	always_ff @(posedge clk_i) begin
		if (adv) begin
			for (int k = 0; k < LB_COUNT; k++) begin
				lb_mem[k][lb_ptr_reg] <= vtap[k];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lb_ptr_reg <= '0;
		end else if (adv) begin
			lb_ptr_reg <= (lb_ptr_reg >= line_len - 12'h001) ? '0 : lb_ptr_reg + 12'h001;
		end
	end

	// ****************************************************************
	// formatting stages
	// ****************************************************************
	// per-filter format register chosen by the latched select
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			h_fmt_reg <= '0;
			v_fmt_reg <= '0;
			s2_v_reg <= 1'b0;
			s3_v_reg <= 1'b0;
		end else if (adv) begin
			h_fmt_reg <= fmt(h_acc, rsl_reg[h_rsl_sel_reg]);
			v_fmt_reg <= fmt(v_acc, rsl_reg[v_rsl_sel_reg]);
			s2_v_reg <= in_v_reg;
			s3_v_reg <= s2_v_reg;
		end
	end

	// concurrent mode sums both results, cascade takes the second filter
	always_comb begin
		if (ortho) begin
			res = sat(ACC_W'(h_fmt_reg) + ACC_W'(v_fmt_reg));
			res_v = s2_v_reg;
		end else begin
			res = mode_reg[MODE_ORDER_BIT] ? h_fmt_reg : v_fmt_reg;
			res_v = s3_v_reg;
		end
	end

	// keep one result in every ratio, 1 to 16
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dec_cnt_reg <= '0;
		end else if (adv && res_v) begin
			dec_cnt_reg <= (dec_cnt_reg == intlv_reg[DECIM_MSB:DECIM_LSB]) ? '0 :
				dec_cnt_reg + 4'h1;
		end
	end

	// ****************************************************************
	// output buffer and register
	// ****************************************************************
	hvf_fifo #(
		.WIDTH(PIX_W),
		.DEPTH(FIFO_DEPTH)
	) u_out_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(adv && res_v && (dec_cnt_reg == 4'h0)),
		.in_ready_o(fifo_in_ready),
		.in_data_i(res),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(out_load),
		.out_data_o(fifo_out_data)
	);

	assign out_load = fifo_out_valid && (!out_v_reg || out_ready_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pixel_out_reg <= '0;
			out_v_reg <= 1'b0;
		end else if (out_load) begin
			pixel_out_reg <= fifo_out_data;
			out_v_reg <= 1'b1;
		end else if (out_ready_i) begin
			out_v_reg <= 1'b0;
		end
	end

	assign pixel_out_o = pixel_out_reg;
	assign pixel_out_valid_o = out_v_reg;
	assign pixel_out_oe_o = !out_en_n_i;
endmodule : hvf_filter

// >>> hvf_filter_checker.sv
/*
 * port checker for hvf_filter: output hand-off, reset and pad enable.
 * assumes one clock, rst_i synchronous active high.
 */
module hvf_filter_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pixel_valid_i,
	input wire logic pixel_ready_o,
	input wire logic out_en_n_i,
	input wire logic out_ready_i,
	input wire hvf_pkg::hvf_pix_t pixel_out_o,
	input wire logic pixel_out_oe_o,
	input wire logic pixel_out_valid_o
);
	import hvf_pkg::*;
	// ****************************************************************
	// helpers
	// ****************************************************************
	logic adv;
	// sample taken this edge
	assign adv = pixel_valid_i && pixel_ready_o;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_quiet;
		!adv [*2];
	endsequence
	sequence s_stall;
		pixel_out_valid_o && !out_ready_i;
	endsequence
	// ****************************************************************
	// properties
	// ****************************************************************
	property p_oe_follow;
		pixel_out_oe_o == !out_en_n_i;
	endproperty
	property p_rst_clear;
		disable iff (1'b0) rst_i |=> pixel_out_o == 12'h000 && !pixel_out_valid_o && pixel_ready_o;
	endproperty
	property p_valid_stands;
		s_stall |=> pixel_out_valid_o;
	endproperty
	property p_data_stands;
		s_stall |=> $stable(pixel_out_o);
	endproperty
	property p_rise_cause;
		$rose(pixel_out_valid_o) |-> $past(adv, 2);
	endproperty
	property p_quiet_hold;
		s_quiet ##0 !pixel_out_valid_o |=> !pixel_out_valid_o;
	endproperty
	property p_full_holds;
		!pixel_ready_o && !out_ready_i |=> !pixel_ready_o;
	endproperty
	property p_full_release;
		!pixel_ready_o && out_ready_i && pixel_out_valid_o |-> ##[1:2] pixel_ready_o;
	endproperty
	a_oe_follow: assert property (p_oe_follow) else $error("pad enable wrong");
	a_rst_clear: assert property (p_rst_clear) else $error("reset state wrong");
	a_valid_stands: assert property (p_valid_stands) else $error("valid dropped");
	a_data_stands: assert property (p_data_stands) else $error("data moved");
	a_rise_cause: assert property (p_rise_cause) else $error("result from no sample");
	a_quiet_hold: assert property (p_quiet_hold) else $error("result from idle");
	a_full_holds: assert property (p_full_holds) else $error("full not held");
	a_full_release: assert property (p_full_release) else $error("full not freed");
	c_full: cover property (!pixel_ready_o);
endmodule : hvf_filter_checker

bind hvf_filter hvf_filter_checker u_hvf_filter_checker (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.pixel_valid_i(pixel_valid_i),
	.pixel_ready_o(pixel_ready_o),
	.out_en_n_i(out_en_n_i),
	.out_ready_i(out_ready_i),
	.pixel_out_o(pixel_out_o),
	.pixel_out_oe_o(pixel_out_oe_o),
	.pixel_out_valid_o(pixel_out_valid_o)
);

// >>> hvf_sink_model.sv
/*
 * downstream pixel sink: reads the resolved pad, paces its ready.
 * assumes the filter's clock and reset.
 */
module hvf_sink_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire hvf_pkg::hvf_pix_t pixel_out_i,
	input wire logic pixel_out_oe_i,
	input wire logic pixel_out_valid_i,
	output logic out_ready_o,
	output logic got_o,
	output hvf_pkg::hvf_pix_t pad_o
);
	import hvf_pkg::*;
	logic [1:0] pace_reg;
	hvf_pix_t last_reg;
	// pad resolution
	// released pad shows inverse of last level, so stale data never matches
	assign pad_o = pixel_out_oe_i ? pixel_out_i : ~last_reg;
	// no reads while pad floats; one stall cycle in four
	assign out_ready_o = !stall_i && pixel_out_oe_i && (pace_reg != 2'h3);
	assign got_o = out_ready_o && pixel_out_valid_i;
	// pacing counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pace_reg <= 2'h0;
		end else begin
			pace_reg <= pace_reg + 2'h1;
		end
	end
	// last driven level, kept while the pad floats
	always_ff @(posedge clk_i) begin
		if (pixel_out_oe_i) last_reg <= pixel_out_i;
	end
endmodule : hvf_sink_model

// >>> testbench.sv
/*
 * testbench for hvf_filter: loads rows and config, streams random pixels.
 * assumes hvf_sink_model on the output and the bound checker.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import hvf_pkg::*;
	logic clk_i, rst_i, pixel_valid_i, pixel_ready_o, hs, ha_en, vs, va_en, primed;
	logic oen, out_ready_i, oe, ovalid, stall, got;
	hvf_pix_t pixel_in_i, pixel_out_o, pad, x1, x2, c0, c1, vc0;
	hvf_pix_t expq[$];
	logic [11:0] hc, vc;
	logic [7:0] ha, va;
	logic [3:0] hsel, vsel, hq, vq;
	logic [31:0] rng;
	int err_count, cmp_count, cycles, skip, taken;
	hvf_filter u_hvf_filter (.clk_i(clk_i), .rst_i(rst_i), .pixel_in_i(pixel_in_i),
		.pixel_valid_i(pixel_valid_i), .pixel_ready_o(pixel_ready_o),
		.horiz_coef_in_i(hc), .horiz_load_strobe_n_i(hs), .horiz_coef_row_addr_i(ha),
		.horiz_addr_latch_en_n_i(ha_en), .vert_coef_in_i(vc), .vert_load_strobe_n_i(vs),
		.vert_coef_row_addr_i(va), .vert_addr_latch_en_n_i(va_en),
		.horiz_format_reg_select_i(hsel), .vert_format_reg_select_i(vsel),
		.out_en_n_i(oen), .out_ready_i(out_ready_i), .pixel_out_o(pixel_out_o),
		.pixel_out_oe_o(oe), .pixel_out_valid_o(ovalid));
	hvf_sink_model u_hvf_sink_model (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
		.pixel_out_i(pixel_out_o), .pixel_out_oe_i(oe), .pixel_out_valid_i(ovalid),
		.out_ready_o(out_ready_i), .got_o(got), .pad_o(pad));
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// format code 1 saturates, 2 halves with rounding, any other wraps
	function automatic hvf_pix_t fmt12(input logic signed [31:0] a, input logic [3:0] f);
		if (f == 4'h2) a = (a + 1) >>> 1;
		if (f == 4'h1 && a > 2047) return 12'h7ff;
		if (f == 4'h1 && a < -2048) return 12'h800;
		return a[11:0];
	endfunction : fmt12
	// concurrent: each result formatted by its select, then saturated total
	function automatic hvf_pix_t exp_pix(input hvf_pix_t x, input hvf_pix_t p);
		logic signed [31:0] h, v;
		h = c0 * x + c1 * p;
		v = vc0 * x;
		return fmt12(32'(fmt12(h, hq)) + 32'(fmt12(v, vq)), 4'h1);
	endfunction : exp_pix
	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("counts: %0d compared, %0d mismatched", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic step();
		@(posedge clk_i);
		#1;
	endtask : step
	task automatic drive_ld(input logic v, input logic sn, input logic [11:0] w);
		if (v) begin
			vs = sn;
			vc = w;
		end else begin
			hs = sn;
			hc = w;
		end
	endtask : drive_ld
	// strobe high one edge, header on the fall, then n data words
	task automatic load(input logic v, input logic [11:0] hdr, input logic [11:0] a,
			input logic [11:0] b, input int n);
		drive_ld(v, 1'b1, 12'h000);
		step();
		drive_ld(v, 1'b0, hdr);
		step();
		for (int k = 0; k < n; k++) begin
			drive_ld(v, 1'b0, k == 0 ? a : (k == 1 ? b : 12'h000));
			step();
		end
	endtask : load
	// a would-be row 1 header plus words; must never land
	task automatic junk(input logic sn);
		drive_ld(1'b0, sn, 12'h001);
		step();
		repeat (8) begin
			drive_ld(1'b0, sn, 12'h7ff);
			step();
		end
	endtask : junk
	task automatic run(input string name, input int n, input int sk);
		skip = sk;
		repeat (n) begin
			rng = xs(rng);
			pixel_valid_i = 1'b1;
			pixel_in_i = rng[11:0];
			hsel = rng[15:12];
			vsel = rng[19:16];
			// hold the sample until the filter takes it
			while (!pixel_ready_o) step();
			step();
		end
		pixel_valid_i = 1'b0;
		repeat (40) step();
		$display("test done: %s", name);
	endtask : run
	// ****************************************************************
	// clock, timeout, scoreboard
	// ****************************************************************
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	always @(posedge clk_i) begin
		if (!rst_i && got && expq.size() > 0) begin
			if (skip > 0) skip--;
			else check("pixel_out", pad, expq[0]);
			void'(expq.pop_front());
		end
		// a sample is formatted when the next is taken, with the selects of the edge before
		if (!rst_i && pixel_valid_i && pixel_ready_o) begin
			if (primed) expq.push_back(exp_pix(x1, x2));
			{x2, x1, primed} = {x1, pixel_in_i, 1'b1};
			taken++;
		end
		{hq, vq} = {hsel, vsel};
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		clk_i = 0;
		rst_i = 1;
		{pixel_valid_i, pixel_in_i, hc, vc, ha, va, hsel, vsel, oen, stall} = '0;
		{hs, vs, ha_en, va_en} = 4'hf;
		{x1, x2, primed, c0, c1, vc0, err_count, cmp_count, cycles, taken} = '0;
		rng = 32'h94f1;
		repeat (16) step();
		rst_i = 0;
		step();
		check("out_rst", pixel_out_o, 12'h000);
		check("valid_rst", {11'h0, ovalid}, 12'h000);
		check("ready_rst", {11'h0, pixel_ready_o}, 12'h001);
		// concurrent mode, all line buffers bypassed
		load(1'b0, 12'h810, 12'h001, 12'h000, 1);
		load(1'b0, 12'h811, 12'h07f, 12'h000, 1);
		// format 1 saturates, format 2 halves with rounding
		load(1'b0, 12'h801, 12'h040, 12'h000, 1);
		load(1'b1, 12'h802, 12'h021, 12'h000, 1);
		load(1'b0, 12'h001, 12'h001, 12'h002, 8);
		junk(1'b0);
		junk(1'b1);
		// vertical row, then horizontal row 2
		load(1'b1, 12'h001, 12'h001, 12'h000, 8);
		load(1'b0, 12'h002, 12'hfff, 12'h000, 8);
		drive_ld(1'b0, 1'b1, 12'h000);
		drive_ld(1'b1, 1'b1, 12'h000);
		{ha, va, ha_en, va_en} = {8'h01, 8'h01, 2'b00};
		step();
		{ha_en, va_en} = 2'b11;
		{c0, c1, vc0} = {12'h001, 12'h002, 12'h001};
		run("row one", 60, 10);
		{ha, ha_en} = {8'h02, 1'b0};
		step();
		ha_en = 1'b1;
		{c0, c1} = {12'hfff, 12'h000};
		run("row two", 60, 2);
		ha = 8'h01;
		run("addr hold", 40, 0);
		// row one untouched by row two load
		ha_en = 1'b0;
		step();
		ha_en = 1'b1;
		{c0, c1} = {12'h001, 12'h002};
		run("row one again", 40, 2);
		// fill the output buffer against a stalled sink
		stall = 1'b1;
		taken = 0;
		pixel_valid_i = 1'b1;
		for (int k = 0; k < 40 && pixel_ready_o; k++) begin
			rng = xs(rng);
			pixel_in_i = rng[11:0];
			oen = rng[20];
			step();
		end
		pixel_valid_i = 1'b0;
		oen = 1'b0;
		check("taken_full", 12'(taken), 12'(FIFO_DEPTH + 1));
		stall = 1'b0;
		run("fill drain", 10, 0);
		print_verdict();
	end
endmodule : testbench
